/* shared/overheat_pkg.sv */
// Purpose: shared constants and types for the power-switch control logic
// Assumes: sys_clk at 250 MHz
// Notes: times in ns, cycle counts derived from the clock period
package overheat_pkg;
	localparam int clk_period_ns = 4;
	localparam int blank_in_fall_ns = 200;
	localparam int blank_in_fall_cyc = (blank_in_fall_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int zc_blank_time_ns = 80;
	localparam int zc_blank_time_cyc = (zc_blank_time_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int zc_detect_delay_ns = 40;
	localparam int zc_detect_delay_cyc = (zc_detect_delay_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int zv_pulse_delay_ns = 40;
	localparam int zv_pulse_delay_cyc = (zv_pulse_delay_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int pulse_width_ns = 100;
	localparam int pulse_width_cyc = (pulse_width_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int reverse_detect_ns = 20;
	localparam int reverse_detect_cyc = (reverse_detect_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int cnt_w = 16;

	typedef enum logic [1:0] {
		st_blank,
		st_watch,
		st_conduct
	} diode_state_t;

	typedef struct packed {
		logic gate_cmd;
		logic drain_negative;
		logic current_forward;
		logic uv_ok;
		logic rail_5v_ok;
		logic neg_rail_ok;
		logic switch_hot;
		logic driver_hot;
	} sense_t;
endpackage

/* rtl/overheat_diode_emulation_fsm.sv */
// Purpose: gate control, overheat diode emulation, zero-volt/current pulses
// Assumes: all sense inputs are asynchronous levels from analog comparators
// Notes: rail-good inputs stand for the analog rail thresholds
`timescale 1ns/1ns
module overheat_diode_emulation_fsm
	import overheat_pkg::*;
#(
	parameter int blank_cyc = blank_in_fall_cyc,
	parameter int zc_blank_time = zc_blank_time_cyc,
	parameter int zc_detect_delay = zc_detect_delay_cyc,
	parameter int zv_pulse_delay = zv_pulse_delay_cyc,
	parameter int zv_pulse_width = pulse_width_cyc,
	parameter int zc_pulse_width = pulse_width_cyc,
	parameter int reverse_conduction_detect_time = reverse_detect_cyc
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Sense and command inputs, asynchronous
	input wire sense_t sense_in,
	// Outputs
	output logic switch_on,
	output logic fault_n,
	output logic zero_volt_pulse_out,
	output logic zero_current_pulse_out,
	output logic overheat_diode_emulation
);

	sense_t s1_q;
	sense_t s2_q;
	logic cmd_prev_q;
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s1_q <= '0;
			s2_q <= '0;
			cmd_prev_q <= 1'b0;
		end
		else
		begin
			s1_q <= sense_in;
			s2_q <= s1_q;
			cmd_prev_q <= s2_q.gate_cmd;
		end
	end

	logic cmd_rise;
	logic cmd_fall;
	assign cmd_rise = s2_q.gate_cmd && !cmd_prev_q;
	assign cmd_fall = !s2_q.gate_cmd && cmd_prev_q;

	function automatic logic [cnt_w-1:0] dec(input logic [cnt_w-1:0] v);
		dec = (v == '0) ? '0 : v - 1'b1;
	endfunction

	// Power-up: rails must both be good; loss of supply restarts
	logic ready_q;
	logic ready_d;
	always_comb
	begin
		ready_d = ready_q;
		// rails stop below lockout, restart on new crossing
		if (!s2_q.uv_ok)
			ready_d = 1'b0;
		// both rails good releases start-up hold
		else if (s2_q.rail_5v_ok && s2_q.neg_rail_ok)
			ready_d = 1'b1;
	end
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			ready_q <= 1'b0;
		else
			ready_q <= ready_d;
	end

	logic hot_mode;
	logic drv_hot;
	assign drv_hot = s2_q.driver_hot;
	// emulation only when switch hot and driver not hot
	assign hot_mode = ready_q && s2_q.switch_hot && !drv_hot;

	// Diode emulation state machine
	diode_state_t st_q;
	diode_state_t st_d;
	logic hot_prev_q;
	logic [cnt_w-1:0] blk_q;
	logic [cnt_w-1:0] blk_d;
	always_comb
	begin
		st_d = st_q;
		blk_d = dec(blk_q);
		if (!hot_mode)
		begin
			st_d = st_watch;
			blk_d = '0;
		end
		else if (!hot_prev_q)
			st_d = st_watch;
		else if (cmd_fall)
		begin
			st_d = st_blank;
			blk_d = cnt_w'(blank_cyc);
		end
		else
		begin
			// no shoot-through counting, plain transitions only
			case (st_q)
				st_blank:
				begin
					if (blk_q <= 16'h0001)
						st_d = st_watch;
				end
				st_watch:
				begin
					if (s2_q.drain_negative)
						st_d = st_conduct;
				end
				default:
				begin
					if (s2_q.current_forward)
						st_d = st_watch;
				end
			endcase
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_q <= st_watch;
			blk_q <= '0;
			hot_prev_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			blk_q <= blk_d;
			hot_prev_q <= hot_mode;
		end
	end

	// Zero-voltage and zero-current pulse generators
	logic [cnt_w-1:0] rev_q;
	logic [cnt_w-1:0] rev_d;
	logic [cnt_w-1:0] zvd_q;
	logic [cnt_w-1:0] zvd_d;
	logic [cnt_w-1:0] zvw_q;
	logic [cnt_w-1:0] zvw_d;
	logic [cnt_w-1:0] zcb_q;
	logic [cnt_w-1:0] zcb_d;
	logic zc_arm_q;
	logic zc_arm_d;
	logic zc_neg_q;
	logic zc_neg_d;
	logic [cnt_w-1:0] zcd_q;
	logic [cnt_w-1:0] zcd_d;
	logic [cnt_w-1:0] zcw_q;
	logic [cnt_w-1:0] zcw_d;
	always_comb
	begin
		rev_d = s2_q.drain_negative ? rev_q + 1'b1 : '0;
		if (rev_q == '1)
			rev_d = rev_q;
		zvd_d = dec(zvd_q);
		zvw_d = dec(zvw_q);
		zcb_d = dec(zcb_q);
		zc_arm_d = zc_arm_q;
		zc_neg_d = zc_neg_q;
		zcd_d = dec(zcd_q);
		zcw_d = dec(zcw_q);
		if (zvd_q == 16'h0001)
			zvw_d = cnt_w'(zv_pulse_width);
		if (zcd_q == 16'h0001)
			zcw_d = cnt_w'(zc_pulse_width);
		// rising edge checks sustained negative drain voltage
		if (cmd_rise && ready_q && rev_q >= cnt_w'(reverse_conduction_detect_time))
			zvd_d = cnt_w'(zv_pulse_delay);
		if (cmd_rise && ready_q)
		begin
			zcb_d = cnt_w'(zc_blank_time);
			zc_arm_d = 1'b1;
			zc_neg_d = 1'b0;
		end
		else if (zc_arm_q && zcb_q == '0)
		begin
			zc_arm_d = 1'b0;
			if (s2_q.current_forward)
				zcw_d = cnt_w'(zc_pulse_width);
			else
				zc_neg_d = 1'b1;
		end
		else if (zc_neg_q && s2_q.current_forward)
		begin
			zc_neg_d = 1'b0;
			zcd_d = cnt_w'(zc_detect_delay);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rev_q <= '0;
			zvd_q <= '0;
			zvw_q <= '0;
			zcb_q <= '0;
			zc_arm_q <= 1'b0;
			zcd_q <= '0;
			zcw_q <= '0;
			zc_neg_q <= 1'b0;
		end
		else
		begin
			rev_q <= rev_d;
			zvd_q <= zvd_d;
			zvw_q <= zvw_d;
			zcb_q <= zcb_d;
			zc_arm_q <= zc_arm_d;
			zcd_q <= zcd_d;
			zcw_q <= zcw_d;
			zc_neg_q <= zc_neg_d;
		end
	end

	// Output registers
	logic sw_d;
	always_comb
	begin
		sw_d = 1'b0;
		if (!ready_q || drv_hot)
			sw_d = 1'b0;
		else if (hot_mode)
			sw_d = (st_d == st_conduct);
		else
			sw_d = s2_q.gate_cmd;
	end
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			switch_on <= 1'b0;
			fault_n <= 1'b0;
			zero_volt_pulse_out <= 1'b0;
			zero_current_pulse_out <= 1'b0;
			overheat_diode_emulation <= 1'b0;
		end
		else
		begin
			switch_on <= sw_d;
			// low during start-up or either overheat
			fault_n <= ready_d && !s2_q.switch_hot && !s2_q.driver_hot;
			zero_volt_pulse_out <= zvw_d != '0;
			zero_current_pulse_out <= zcw_d != '0;
			overheat_diode_emulation <= hot_mode;
		end
	end

	chk_fall_to_blank: assert property (@(posedge sys_clk) disable iff (!reset_n)
		hot_mode && hot_prev_q && cmd_fall |=> st_q == st_blank && !switch_on)
		else $error("falling edge did not enter blank state");
	chk_blank_leaves: assert property (@(posedge sys_clk) disable iff (!reset_n)
		st_q == st_blank && hot_mode && !cmd_fall && blk_q == 16'h0001 |=> st_q == st_watch)
		else $error("blank state did not end on time");
	chk_watch_to_conduct: assert property (@(posedge sys_clk) disable iff (!reset_n)
		hot_mode && hot_prev_q && st_q == st_watch && s2_q.drain_negative && !cmd_fall
		|=> st_q == st_conduct)
		else $error("reverse flow ignored");
	chk_entry_watch: assert property (@(posedge sys_clk) disable iff (!reset_n)
		hot_mode && !hot_prev_q |=> st_q == st_watch)
		else $error("overheat entry not in watch state");
	chk_conduct_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
		hot_mode && st_d == st_conduct |=> switch_on)
		else $error("conduct state without switch on");
	chk_driver_hot_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
		drv_hot |=> !switch_on && !fault_n)
		else $error("switch on during driver overheat");
	chk_startup_fault: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!ready_q && !ready_d |=> !fault_n)
		else $error("fault released before rails good");
	chk_zv_pulse_width: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(zero_volt_pulse_out) |-> zero_volt_pulse_out [*2])
		else $error("zero-volt pulse too short");
	chk_fault_on_hot: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s2_q.switch_hot || s2_q.driver_hot |=> !fault_n)
		else $error("fault not shown in overheat");
endmodule

/* tb/controller_model.sv */
// Purpose: converter controller model that drives the gate command
// Assumes: requests from the bench change on sys_clk rising edges
// Notes: the command is launched one edge after the request
`timescale 1ns/1ns
module controller_model
(
	// Clock
	input wire logic sys_clk,
	// Request from the bench
	input wire logic cmd_req,
	// Command to the block
	output logic gate_cmd
);
	always @(posedge sys_clk)
	begin
		gate_cmd <= cmd_req;
	end
endmodule

/* tb/test_overheat_diode_emulation_fsm.sv */
// Purpose: self-checking bench for the overheat diode emulation block
// Assumes: timing parameters shrunk so that each phase is a few cycles
// Notes: outputs are sampled 1 ns after each rising edge
`timescale 1ns/1ns
module test_overheat_diode_emulation_fsm;
	import overheat_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic cmd_req = 1'b0;
	logic gate_cmd;
	sense_t s = '0;
	sense_t sense_in;
	logic switch_on, fault_n, zv, zc, emul;
	logic o_on, o_fault, o_emul, seen_zv, seen_zc;
	int fails = 0;
	int checked = 0;
	always_comb
	begin
		sense_in = s;
		sense_in.gate_cmd = gate_cmd;
	end
	initial
	begin
		forever #2 sys_clk = ~sys_clk;
	end
	controller_model i_controller_model(.sys_clk(sys_clk), .cmd_req(cmd_req),
		.gate_cmd(gate_cmd));
	overheat_diode_emulation_fsm #(.blank_cyc(8), .zc_blank_time(4), .zv_pulse_delay(2),
		.zv_pulse_width(3), .zc_pulse_width(3)) i_overheat_diode_emulation_fsm(
		.sys_clk(sys_clk), .reset_n(reset_n), .sense_in(sense_in),
		.switch_on(switch_on), .fault_n(fault_n), .zero_volt_pulse_out(zv),
		.zero_current_pulse_out(zc), .overheat_diode_emulation(emul));
	task automatic chk(input logic seen, input logic exp, input string what);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %b want %b", $time, what, seen, exp);
		end
	endtask
	// Starts and ends on a rising edge, keeps the last settled values
	task automatic run(input int n);
		seen_zv = 1'b0;
		seen_zc = 1'b0;
		repeat (n)
		begin
			#1;
			o_on = switch_on;
			o_fault = fault_n;
			o_emul = emul;
			seen_zv = seen_zv | zv;
			seen_zc = seen_zc | zc;
			@(posedge sys_clk);
		end
	endtask
	task automatic t_start;
		run(6);
		chk(o_fault, 1'b0, "fault before supply");
		s.uv_ok <= 1'b1;
		s.rail_5v_ok <= 1'b1;
		run(8);
		chk(o_fault, 1'b0, "fault with one rail");
		s.neg_rail_ok <= 1'b1;
		run(8);
		chk(o_fault, 1'b1, "fault after rails");
		s.uv_ok <= 1'b0;
		run(6);
		chk(o_fault, 1'b0, "fault on supply dip");
		s.uv_ok <= 1'b1;
		run(6);
		chk(o_fault, 1'b1, "fault after new crossing");
		$display("test start done");
	endtask
	task automatic t_follow;
		cmd_req <= 1'b1;
		run(6);
		chk(o_on, 1'b1, "switch follows rise");
		cmd_req <= 1'b0;
		run(6);
		chk(o_on, 1'b0, "switch follows fall");
		$display("test follow done");
	endtask
	task automatic t_hot;
		s.switch_hot <= 1'b1;
		run(6);
		chk(o_fault, 1'b0, "fault in overheat");
		chk(o_emul, 1'b1, "emulation on");
		chk(o_on, 1'b0, "entry state off");
		s.drain_negative <= 1'b1;
		run(6);
		chk(o_on, 1'b1, "reverse turns on");
		s.drain_negative <= 1'b0;
		s.current_forward <= 1'b1;
		run(6);
		chk(o_on, 1'b0, "forward turns off");
		s.current_forward <= 1'b0;
		s.drain_negative <= 1'b1;
		run(6);
		chk(o_on, 1'b1, "second reverse on");
		$display("test hot done");
	endtask
	// controller toggles the hot switch first
	task automatic t_fall;
		cmd_req <= 1'b1;
		run(4);
		cmd_req <= 1'b0;
		run(5);
		chk(o_on, 1'b0, "off after fall");
		run(6);
		chk(o_on, 1'b0, "blank ignores drain");
		run(6);
		chk(o_on, 1'b1, "blank ends by time");
		cmd_req <= 1'b1;
		run(4);
		cmd_req <= 1'b0;
		run(5);
		chk(o_on, 1'b0, "repeated fall off");
		run(6);
		chk(o_on, 1'b0, "repeated blank off");
		run(6);
		chk(o_on, 1'b1, "repeated cycle on");
		$display("test fall done");
	endtask
	task automatic t_driver;
		s.driver_hot <= 1'b1;
		run(6);
		chk(o_on, 1'b0, "forced off");
		chk(o_emul, 1'b0, "no emulation");
		s.driver_hot <= 1'b0;
		run(6);
		chk(o_emul, 1'b1, "emulation resumes");
		chk(o_fault, 1'b0, "fault stays");
		s.switch_hot <= 1'b0;
		s.drain_negative <= 1'b0;
		run(8);
		chk(o_fault, 1'b1, "fault clears");
		chk(o_emul, 1'b0, "emulation ends");
		$display("test driver done");
	endtask
	task automatic t_zero;
		s.drain_negative <= 1'b1;
		run(6);
		cmd_req <= 1'b1;
		run(12);
		chk(seen_zv, 1'b1, "zero volt pulse");
		chk(seen_zc, 1'b0, "no crossing yet");
		s.current_forward <= 1'b1;
		run(18);
		chk(seen_zc, 1'b1, "pulse after crossing");
		cmd_req <= 1'b0;
		s.drain_negative <= 1'b0;
		run(8);
		cmd_req <= 1'b1;
		run(12);
		chk(seen_zv, 1'b0, "hard switching");
		chk(seen_zc, 1'b1, "forward at blank end");
		cmd_req <= 1'b0;
		s.current_forward <= 1'b0;
		run(4);
		s.drain_negative <= 1'b1;
		cmd_req <= 1'b1;
		run(12);
		chk(seen_zv, 1'b0, "short reverse conduction");
		cmd_req <= 1'b0;
		s.drain_negative <= 1'b0;
		run(4);
		$display("test zero done");
	endtask
	task automatic print_verdict;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_start;
		t_follow;
		t_hot;
		t_fall;
		t_driver;
		t_zero;
		print_verdict;
	end
	// Tests need about 212 cycles
	initial
	begin
		#20000;
		fails++;
		print_verdict;
	end
endmodule
